/* rtl/pcm_osc_monitor.sv */
// oscillator pin selection, synchroniser, period and loss detector
`timescale 1ns/100ps
module pcm_osc_monitor (
    input  wire logic                           clk_sys,
    input  wire logic                           srst,
    input  wire logic                           crystal_in_pin,
    input  wire logic                           ext_clock_pin,
    input  wire logic                           ext_clock_mode,
    output logic                                osc_rise,
    output logic [pcm_pkg::PERIOD_W-1:0]        osc_period,
    output logic                                osc_missing,
    output logic                                osc_seen
);
    import pcm_pkg::*;

    logic                osc_raw;       // selected input clock
    logic                sync1_q;       // first synchroniser stage
    logic                sync2_q;       // second synchroniser stage
    logic                sync3_q;       // edge history
    logic [PERIOD_W-1:0] idle_q;        // cycles since last edge
    logic [PERIOD_W-1:0] period_q;      // last full period
    logic                seen_q;        // oscillator ever toggled

    // external mode: the unused pin is tied low, so or the two
    assign osc_raw = ext_clock_mode ? (crystal_in_pin | ext_clock_pin)
                                    : crystal_in_pin;

    // two flops before anything looks at the pin
    always_ff @(posedge clk_sys) begin
        sync1_q <= osc_raw;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    assign osc_rise    = sync2_q & ~sync3_q;
    assign osc_missing = (idle_q >= MISS_CYCLES);
    assign osc_period  = period_q;
    assign osc_seen    = seen_q;

    // period measurement, saturating so a dead clock cannot wrap
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            idle_q   <= '0;
            period_q <= '1;
            seen_q   <= 1'b0;
        end else if (osc_rise) begin
            idle_q   <= '0;
            period_q <= idle_q + 16'h0001;
            seen_q   <= 1'b1;
        end else if (!osc_missing) begin
            idle_q   <= idle_q + 16'h0001;
        end
    end

    default clocking cb_mon @(posedge clk_sys); endclocking
    default disable iff (srst);

    // loss is declared only after the full idle window
    property p_miss_window;
        osc_missing |-> $past(idle_q) >= (MISS_CYCLES - 16'h0001);
    endproperty
    a_miss_window: assert property (p_miss_window)
        else $error("missing declared before idle window");

endmodule : pcm_osc_monitor

/* rtl/pcm_pkg.sv */
// shared constants, modes and status carrier of the pll clock module
package pcm_pkg;

    localparam int          RATIO_W         = 4;      // ratio field width
    localparam int          PRESC_W         = 2;      // prescaler select width
    localparam int          PERIOD_W        = 16;     // measured osc period
    localparam int          LOCK_W          = 17;     // lock counter width
    localparam logic [3:0]  RATIO_RST       = 4'h0;   // bypass at reset
    localparam logic [3:0]  RATIO_MAX       = 4'hA;   // highest legal ratio
    localparam logic [1:0]  PRESC_RST       = 2'h0;   // divide-by-four
    localparam logic [1:0]  PRESC_DIV2      = 2'h2;   // divide-by-two code
    localparam logic [1:0]  PRESC_DIV1      = 2'h3;   // divide-by-one code
    localparam logic [1:0]  TERM_DIV4       = 2'h3;   // prescaler terminal /4
    localparam logic [1:0]  TERM_DIV2       = 2'h1;   // prescaler terminal /2
    localparam logic [1:0]  TERM_DIV1       = 2'h0;   // prescaler terminal /1
    // pll settling time counted in oscillator periods
    localparam int          LOCK_OSC_CYCLES = 131072;
    // clock rate and limp-mode target
    localparam int          CLK_SYS_KHZ     = 250000;
    localparam int          LIMP_KHZ        = 2500;   // typical 1..5 MHz
    localparam int          LIMP_DIV        = CLK_SYS_KHZ / LIMP_KHZ;
    localparam logic [7:0]  LIMP_TERM       = 8'(LIMP_DIV - 1);
    // idle clk_sys cycles before oscillator is declared missing
    localparam logic [15:0] MISS_CYCLES     = 16'h0100;

    // operating modes of the pll
    typedef enum logic [3:0] {
        ST_BYPASS = 4'b0001,    // pll running, not used
        ST_LOCK   = 4'b0010,    // bypassed while pll locks
        ST_ENABLE = 4'b0100,    // multiplied clock in use
        ST_OFF    = 4'b1000     // pll powered down
    } pcm_mode_t;

    // status bits seen by software
    typedef struct packed {
        logic pll_power_down_bit;   // pll held off
        logic pll_lock_flag;        // pll locked at current ratio
        logic missing_clock_flag;   // oscillator loss seen
        logic limp_active;          // cpu running on limp clock
    } pcm_status_t;

endpackage : pcm_pkg

/* rtl/pcm_pll_clock_module.sv */
// pll mode control, clock multiplication, prescaler and limp fallback
`timescale 1ns/100ps
module pcm_pll_clock_module #(
    parameter int unsigned LOCK_OSC_CYCLES = pcm_pkg::LOCK_OSC_CYCLES
) (
    input  wire logic                           clk_sys,
    input  wire logic                           srst,
    input  wire logic                           crystal_in_pin,
    input  wire logic                           ext_clock_pin,
    input  wire logic                           ext_clock_mode,
    input  wire logic                           external_reset_pin_n,
    input  wire logic                           watchdog_reset,
    input  wire logic                           protected_write_gate,
    input  wire logic                           ratio_wr,
    input  wire logic [pcm_pkg::RATIO_W-1:0]    ratio_wdata,
    input  wire logic                           state_wr,
    input  wire logic [pcm_pkg::PRESC_W-1:0]    prescale_wdata,
    input  wire logic                           power_down_wdata,
    input  wire logic                           mclk_clear,
    output logic [pcm_pkg::RATIO_W-1:0]         pll_ratio_reg,
    output logic [pcm_pkg::PRESC_W-1:0]         cpu_clock_prescale_sel,
    output pcm_pkg::pcm_status_t                pll_state_reg,
    output logic                                cpu_clk_en,
    output logic                                system_clock_out_en,
    output logic                                device_reset_req,
    output logic                                watchdog_hold
);
    import pcm_pkg::*;

    // prescaler terminal count for a select code
    function automatic logic [1:0] presc_term(input logic [1:0] sel);
        unique case (sel)
            PRESC_DIV1: presc_term = TERM_DIV1;
            PRESC_DIV2: presc_term = TERM_DIV2;
            default:    presc_term = TERM_DIV4;    // codes 0 and 1
        endcase
    endfunction : presc_term

    // legal multiplier test, reserved codes fall back to bypass
    function automatic logic ratio_ok(input logic [3:0] r);
        ratio_ok = (r != RATIO_RST) && (r <= RATIO_MAX);
    endfunction : ratio_ok

    logic                osc_rise;       // oscillator rising edge
    logic [PERIOD_W-1:0] osc_period;     // oscillator period in cycles
    logic                osc_missing;    // oscillator idle too long
    logic                osc_seen;       // oscillator once present
    logic                xrs_s1_q;       // reset pin stage one
    logic                xrs_s2_q;       // reset pin stage two
    logic                reg_rst;        // register-domain reset
    logic [3:0]          ratio_q;        // multiplier register
    logic [1:0]          presc_q;        // prescaler select
    logic                pd_q;           // power-down bit
    logic                lock_q;         // lock flag
    logic                mflag_q;        // sticky missing flag
    pcm_mode_t           mode_q;         // current mode
    pcm_mode_t           mode_d;         // next mode
    logic [LOCK_W-1:0]   lock_cnt_q;     // osc periods since write
    logic                lock_done;      // settling time reached
    logic                ratio_acc;      // accepted ratio write
    logic [16:0]         acc_q;          // vco phase accumulator
    logic [16:0]         acc_sum;        // accumulator plus ratio
    logic                vco_tick;       // multiplied clock edge
    logic [7:0]          limp_cnt_q;     // limp divider
    logic                limp_tick;      // limp clock edge
    logic                limp_active;    // running on limp clock
    logic                limp_q;         // registered limp state
    logic                src_tick;       // edge entering prescaler
    logic [1:0]          div_cnt_q;      // prescaler counter
    logic                clk_en_q;       // registered cpu enable
    logic                fail_evt;       // onset of clock loss
    logic                rst_req_q;      // registered reset request

    pcm_osc_monitor u_osc (
        .clk_sys        (clk_sys),
        .srst           (srst),
        .crystal_in_pin (crystal_in_pin),
        .ext_clock_pin  (ext_clock_pin),
        .ext_clock_mode (ext_clock_mode),
        .osc_rise       (osc_rise),
        .osc_period     (osc_period),
        .osc_missing    (osc_missing),
        .osc_seen       (osc_seen)
    );

    // reset pin comes from outside, so synchronise it
    always_ff @(posedge clk_sys) begin
        xrs_s1_q <= external_reset_pin_n;
        xrs_s2_q <= xrs_s1_q;
    end

    // only pin, watchdog and power-on reach the registers
    assign reg_rst   = srst | ~xrs_s2_q | watchdog_reset;
    assign ratio_acc = ratio_wr & protected_write_gate;
    assign lock_done = osc_rise &&
                       (lock_cnt_q == LOCK_W'(LOCK_OSC_CYCLES - 1));

    // software registers; missing-clock reset leaves them alone
    always_ff @(posedge clk_sys) begin
        if (reg_rst) begin
            ratio_q <= RATIO_RST;
            presc_q <= PRESC_RST;
            pd_q    <= 1'b0;
        end else begin
            if (ratio_acc) ratio_q <= ratio_wdata;
            if (state_wr) begin
                presc_q <= prescale_wdata;
                pd_q    <= power_down_wdata;
            end
        end
    end

    // mode selection: a write drops to bypass until lock
    always_comb begin
        mode_d = mode_q;
        if (pd_q) begin
            mode_d = ST_OFF;
        end else if (!ratio_ok(ratio_q)) begin
            mode_d = ST_BYPASS;
        end else begin
            unique case (mode_q)
                ST_BYPASS: mode_d = ST_LOCK;
                ST_OFF:    mode_d = ST_LOCK;    // pll restarts
                ST_LOCK:   mode_d = lock_done ? ST_ENABLE : ST_LOCK;
                ST_ENABLE: mode_d = ST_ENABLE;
            endcase
        end
        if (ratio_acc && !pd_q) begin
            mode_d = ratio_ok(ratio_wdata) ? ST_LOCK : ST_BYPASS;
        end
    end

    // mode, lock counter and lock flag
    always_ff @(posedge clk_sys) begin
        if (reg_rst) begin
            mode_q     <= ST_BYPASS;
            lock_cnt_q <= '0;
            lock_q     <= 1'b0;
        end else begin
            mode_q <= mode_d;
            // a rewrite restarts settling at the new ratio
            if (ratio_acc || mode_d != ST_LOCK || mode_q != ST_LOCK) begin
                lock_cnt_q <= '0;
            end else if (osc_rise) begin
                lock_cnt_q <= lock_cnt_q + 17'h00001;
            end
            if (ratio_acc || pd_q) lock_q <= 1'b0;
            else if (lock_done && mode_q == ST_LOCK) lock_q <= 1'b1;
        end
    end

    // vco model: ratio edges per oscillator period, phase accumulator
    assign acc_sum  = acc_q + {13'h0000, ratio_q};
    assign vco_tick = (acc_sum >= {1'b0, osc_period});
    always_ff @(posedge clk_sys) begin
        if (srst) acc_q <= '0;
        else if (vco_tick) acc_q <= acc_sum - {1'b0, osc_period};
        else acc_q <= acc_sum;
    end

    // free-running limp oscillator stand-in
    assign limp_tick = (limp_cnt_q == LIMP_TERM);
    always_ff @(posedge clk_sys) begin
        if (srst || limp_tick) limp_cnt_q <= '0;
        else limp_cnt_q <= limp_cnt_q + 8'h01;
    end

    // limp only with the pll on and a clock once seen
    assign limp_active = osc_missing & osc_seen & (mode_q != ST_OFF);

    // source ahead of the prescaler; bypass and lock use the osc
    assign src_tick = limp_active          ? limp_tick :
                      (mode_q == ST_ENABLE) ? vco_tick  : osc_rise;

    // post-divider; cpu and system clock enables share it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_cnt_q <= '0;
            clk_en_q  <= 1'b0;
        end else begin
            clk_en_q <= src_tick && (div_cnt_q >= presc_term(presc_q));
            if (src_tick) begin
                if (div_cnt_q >= presc_term(presc_q)) div_cnt_q <= '0;
                else div_cnt_q <= div_cnt_q + 2'h1;
            end
        end
    end

    // clock-loss event: device reset and sticky flag, set wins
    assign fail_evt = limp_active & ~limp_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            limp_q    <= 1'b0;
            mflag_q   <= 1'b0;
            rst_req_q <= 1'b0;
        end else begin
            limp_q    <= limp_active;
            rst_req_q <= fail_evt;
            if (fail_evt) mflag_q <= 1'b1;
            else if (mclk_clear) mflag_q <= 1'b0;
        end
    end

    assign pll_ratio_reg          = ratio_q;
    assign cpu_clock_prescale_sel = presc_q;
    assign pll_state_reg          = '{pll_power_down_bit: pd_q,
                                      pll_lock_flag:      lock_q,
                                      missing_clock_flag: mflag_q,
                                      limp_active:        limp_q};
    assign cpu_clk_en             = clk_en_q;
    assign system_clock_out_en    = clk_en_q;
    assign device_reset_req       = rst_req_q;
    assign watchdog_hold          = limp_q;

    default clocking cb_top @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_gate_closed;
        ratio_wr && !protected_write_gate && !reg_rst |=> $stable(ratio_q);
    endproperty
    a_gate_closed: assert property (p_gate_closed)
        else $error("ratio changed with write gate closed");

    property p_write_bypass;
        ratio_acc && !reg_rst |=> mode_q != ST_ENABLE && !lock_q
            && lock_cnt_q == '0;
    endproperty
    a_write_bypass: assert property (p_write_bypass)
        else $error("ratio write did not force bypass");

    property p_enable_locked;
        mode_q == ST_ENABLE |-> lock_q;
    endproperty
    a_enable_locked: assert property (p_enable_locked)
        else $error("multiplied clock used without lock");

    property p_power_down;
        state_wr && power_down_wdata && !reg_rst |=> ##1 mode_q == ST_OFF;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down bit did not stop pll");

    property p_zero_bypass;
        ratio_q == RATIO_RST && !pd_q && $past(ratio_q) == RATIO_RST
            && $past(!pd_q) |-> mode_q == ST_BYPASS;
    endproperty
    a_zero_bypass: assert property (p_zero_bypass)
        else $error("ratio zero but not in bypass");

    property p_div1;
        presc_q == PRESC_DIV1 && $past(presc_q) == PRESC_DIV1
            |-> clk_en_q == $past(src_tick);
    endproperty
    a_div1: assert property (p_div1)
        else $error("divide-by-one does not pass every edge");

    property p_loss_reset;
        fail_evt |=> device_reset_req && mflag_q && watchdog_hold;
    endproperty
    a_loss_reset: assert property (p_loss_reset)
        else $error("clock loss without reset request and flag");

    property p_no_cold_limp;
        !osc_seen |-> ##1 !watchdog_hold;
    endproperty
    a_no_cold_limp: assert property (p_no_cold_limp)
        else $error("limp clock used before oscillator seen");

    property p_limp_route;
        limp_active && limp_tick |-> src_tick;
    endproperty
    a_limp_route: assert property (p_limp_route)
        else $error("limp edge not routed to prescaler");

    c_lock_reached: cover property (mode_q == ST_LOCK ##1 mode_q == ST_ENABLE);
    c_clock_loss:   cover property (fail_evt ##1 device_reset_req);
    c_power_off:    cover property ($rose(mode_q == ST_OFF));
    c_set_and_clr:  cover property (fail_evt && mclk_clear);

endmodule : pcm_pll_clock_module

/* verification/pcm_pll_clock_module_tb.sv */
// self-checking bench for the pll clock module, queue-based scoreboard
`timescale 1ns/100ps
`define CHECK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
end
module pcm_pll_clock_module_tb;
    import pcm_pkg::*;
    localparam int LOCK_N  = 8;      // shortened settling count
    localparam int WIN     = 512;    // window = 32 oscillator periods
    localparam int T_LIMIT = 30000;  // hang ceiling in clk_sys cycles
    // expected result awaiting its observation
    typedef struct {
        int          sel;
        logic [15:0] exp;
        int          tol;
    } pcm_note_t;
    logic                clk_sys, srst, ext_clock_mode;
    logic                crystal_in_pin, ext_clock_pin;
    logic                external_reset_pin_n, watchdog_reset;
    logic                protected_write_gate, ratio_wr, state_wr;
    logic [RATIO_W-1:0]  ratio_wdata;
    logic [PRESC_W-1:0]  prescale_wdata;
    logic                power_down_wdata, mclk_clear;
    logic [RATIO_W-1:0]  pll_ratio_reg;
    logic [PRESC_W-1:0]  cpu_clock_prescale_sel;
    pcm_status_t         pll_state_reg;
    logic                cpu_clk_en, system_clock_out_en;
    logic                device_reset_req, watchdog_hold;
    logic                osc_lvl, osc_on, osc_ext;   // oscillator model
    int                  pulse_cnt, rr_cnt, diff_cnt, cyc;
    int                  fail_count, samples_checked;
    logic [3:0]          n;
    logic [1:0]          pc;
    pcm_note_t           notes[$];
    event                obs_ev;

    pcm_pll_clock_module #(.LOCK_OSC_CYCLES(LOCK_N)) u_dut (
        .clk_sys(clk_sys), .srst(srst),
        .crystal_in_pin(crystal_in_pin), .ext_clock_pin(ext_clock_pin),
        .ext_clock_mode(ext_clock_mode),
        .external_reset_pin_n(external_reset_pin_n),
        .watchdog_reset(watchdog_reset),
        .protected_write_gate(protected_write_gate),
        .ratio_wr(ratio_wr), .ratio_wdata(ratio_wdata),
        .state_wr(state_wr), .prescale_wdata(prescale_wdata),
        .power_down_wdata(power_down_wdata), .mclk_clear(mclk_clear),
        .pll_ratio_reg(pll_ratio_reg),
        .cpu_clock_prescale_sel(cpu_clock_prescale_sel),
        .pll_state_reg(pll_state_reg), .cpu_clk_en(cpu_clk_en),
        .system_clock_out_en(system_clock_out_en),
        .device_reset_req(device_reset_req), .watchdog_hold(watchdog_hold)
    );

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // slow oscillator, 16 clk_sys per period, stoppable to fake a loss
    initial begin
        osc_lvl = 1'b0;
        forever begin
            repeat (8) @(negedge clk_sys);
            if (osc_on) osc_lvl = ~osc_lvl;
        end
    end
    // idle pin held low so only the selected source toggles
    assign crystal_in_pin = osc_ext ? 1'b0 : osc_lvl;
    assign ext_clock_pin  = osc_ext ? osc_lvl : 1'b0;
    // output event counters and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cpu_clk_en === 1'b1) pulse_cnt++;
        if (device_reset_req === 1'b1) rr_cnt++;
        if (cpu_clk_en !== system_clock_out_en) diff_cnt++;
        if (cyc == T_LIMIT) begin
            fail_count++;
            end_sim();
        end
    end
    // observed value for a note selector
    function automatic logic [15:0] observe(input int sel);
        case (sel)
            0: return {12'h000, pll_ratio_reg};
            1: return {14'h0000, cpu_clock_prescale_sel};
            2: return {12'h000, pll_state_reg};
            3: return pulse_cnt[15:0];
            4: return rr_cnt[15:0];
            6: return {15'h0000, watchdog_hold};
            default: return diff_cnt[15:0];
        endcase
    endfunction : observe
    // scoreboard: drains every pending note, oldest first, whenever results are posted
    initial begin
        pcm_note_t   nt;
        logic [15:0] got;
        forever begin
            @(obs_ev);
            while (notes.size() > 0) begin
                nt  = notes.pop_front();
                got = observe(nt.sel);
                // rate counts may be off by the prescaler phase
                if (nt.tol > 0 && got <= nt.exp + nt.tol
                    && got + nt.tol >= nt.exp) got = nt.exp;
                `CHECK(got, nt.exp)
            end
        end
    end

    task automatic note(input int sel, input logic [15:0] e, input int t);
        notes.push_back('{sel, e, t});
    endtask : note
    // post the results now settled, then move off the edge
    task automatic flush();
        ->obs_ev;
        @(negedge clk_sys);
    endtask : flush
    task automatic waitc(input int c);
        repeat (c) @(negedge clk_sys);
    endtask : waitc
    task automatic wr_ratio(input logic [3:0] v, input logic g);
        @(negedge clk_sys);
        ratio_wr = 1'b1;
        ratio_wdata = v;
        protected_write_gate = g;
        @(negedge clk_sys);
        ratio_wr = 1'b0;
        protected_write_gate = 1'b0;
    endtask : wr_ratio
    task automatic wr_state(input logic [1:0] p, input logic pd);
        @(negedge clk_sys);
        state_wr = 1'b1;
        prescale_wdata = p;
        power_down_wdata = pd;
        @(negedge clk_sys);
        state_wr = 1'b0;
    endtask : wr_state
    // count cpu clock pulses over a window and note the expectation
    task automatic window(input int c, input logic [15:0] e, input int t);
        pulse_cnt = 0;
        waitc(c);
        note(3, e, t);
        flush();
    endtask : window
    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // main sequence, inputs change on the falling edge only
    initial begin
        logic [1:0]  codes[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [15:0] rates[4] = '{16'h0008, 16'h0010, 16'h0020, 16'h0008};
        {ext_clock_mode, watchdog_reset, protected_write_gate} = 3'h0;
        {ratio_wr, state_wr, power_down_wdata, mclk_clear} = 4'h0;
        {ratio_wdata, prescale_wdata} = 6'h00;
        {osc_on, osc_ext} = 2'h0;
        {pulse_cnt, rr_cnt, diff_cnt, cyc} = '0;
        {fail_count, samples_checked} = '0;
        external_reset_pin_n = 1'b1;
        srst = 1'b1;
        void'($urandom(32'hB8FE));
        waitc(4);
        srst = 1'b0;
        osc_on = 1'b1;
        waitc(64);
        note(0, 16'h0000, 0);
        note(1, 16'h0000, 0);
        note(2, 16'h0000, 0);
        window(WIN, 16'h0008, 1);
        // every prescaler code in bypass, divide-by-one allowed here
        for (int i = 0; i < 4; i++) begin
            wr_state(codes[i], 1'b0);
            note(1, {14'h0000, codes[i]}, 0);
            window(WIN, rates[i], 1);
        end
        wr_ratio(4'h5, 1'b0);
        note(0, 16'h0000, 0);
        flush();
        // random ratio then back-to-back rewrite with the top ratio
        n = 4'($urandom_range(10, 1));
        for (int k = 0; k < 2; k++) begin
            pc = ($urandom_range(1, 0) == 1) ? 2'h2 : 2'h0;
            wr_state(2'h0, 1'b0);
            if (k == 1) wr_ratio(4'h2, 1'b1);
            wr_ratio(k == 0 ? n : 4'hA, 1'b1);
            note(0, {12'h000, k == 0 ? n : 4'hA}, 0);
            note(2, 16'h0000, 0);
            flush();
            waitc(16 * (LOCK_N + 4));
            note(2, 16'h0004, 0);
            flush();
            wr_state(pc, 1'b0);
            window(WIN, 16'((32 * (k == 0 ? n : 10)) / (pc == 2 ? 2 : 4)),
                   2);
        end
        // reserved ratio is kept but never locks
        wr_state(2'h0, 1'b0);
        wr_ratio(4'hB, 1'b1);
        waitc(16 * (LOCK_N + 4));
        note(0, 16'h000B, 0);
        note(2, 16'h0000, 0);
        window(WIN, 16'h0008, 1);
        // power down after selecting bypass
        wr_ratio(4'h0, 1'b1);
        wr_state(2'h0, 1'b1);
        waitc(3);
        note(2, 16'h0008, 0);
        window(WIN, 16'h0008, 1);
        wr_state(2'h0, 1'b0);
        // watchdog reset and reset pin both restore defaults
        wr_ratio(4'h3, 1'b1);
        watchdog_reset = 1'b1;
        waitc(1);
        watchdog_reset = 1'b0;
        waitc(2);
        note(0, 16'h0000, 0);
        flush();
        wr_ratio(4'h3, 1'b1);
        external_reset_pin_n = 1'b0;
        waitc(1);
        external_reset_pin_n = 1'b1;
        waitc(4);
        note(0, 16'h0000, 0);
        flush();
        // external clock pin as source
        osc_ext = 1'b1;
        ext_clock_mode = 1'b1;
        window(WIN, 16'h0008, 1);
        osc_ext = 1'b0;
        ext_clock_mode = 1'b0;
        // oscillator loss in bypass: reset request, limp clock, hold
        rr_cnt = 0;
        osc_on = 1'b0;
        waitc(300);
        note(4, 16'h0001, 0);
        note(2, 16'h0003, 0);
        note(6, 16'h0001, 0);
        window(1200, 16'h0003, 1);
        osc_on = 1'b1;
        waitc(64);
        note(2, 16'h0002, 0);
        note(6, 16'h0000, 0);
        flush();
        mclk_clear = 1'b1;
        waitc(1);
        mclk_clear = 1'b0;
        waitc(2);
        note(2, 16'h0000, 0);
        note(5, 16'h0000, 0);
        flush();
        // no limp from power-up when the oscillator was never seen
        srst = 1'b1;
        osc_on = 1'b0;
        waitc(4);
        srst = 1'b0;
        rr_cnt = 0;
        waitc(300);
        note(4, 16'h0000, 0);
        flush();
        end_sim();
    end
endmodule : pcm_pll_clock_module_tb
